//--- design/orm_byte_reg.sv
// Byte register with write enable and synchronous clear
`timescale 1ns/1ps
module orm_byte_reg #(
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter logic [7:0] WR_MASK = 8'hff
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic clr,
   input wire logic we,
   input wire logic [7:0] d,
   output logic [7:0] q
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Clear wins over write: a reset command must leave known state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= RST_VAL;
      end else if (ce) begin
         if (clr) begin
            q <= RST_VAL;
         end else if (we) begin
            q <= d & WR_MASK; // Masked bits stay at zero
         end
      end
   end
endmodule

//--- design/orm_overlay_ctrl.sv
// Overlay register bank, dump/restore access port and mode strap control
//
// What this block does
// - Bank bit 2 maps address 13 to dump port
// - Port write feeds dump path, read returns dump
// - Dump mode comes from configuration register 2
// - Mode bits decode coefficient, arctap read/write, serial
// - Hardware and software reset clear dump port
// - Bank select visible in both register sets
// - After reset both clock outputs are enabled
// - Legacy clock bits reserved; disable via register 3
// - GCI strap enables C/I and Monitor channels
// - Master strap high selects master timing
// - Parallel port uses chip select and direction
// - Registers give access to maintenance channel
`timescale 1ns/1ps
module orm_overlay_ctrl #(
   parameter int ADDR_W = 5
) (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic SOFT_RST,
   input wire logic CTRL_SELECT_STRAP,
   input wire logic PORT_SELECT_STRAP,
   input wire logic MASTER_STRAP,
   input wire orm_pkg::orm_pcp_req_s PCP_REQ,
   output logic [7:0] PCP_DOUT,
   output logic PCP_DOE,
   output logic DUMP_WR_STB,
   output logic [7:0] DUMP_WR_DATA,
   output logic DUMP_RD_STB,
   input wire logic [7:0] DUMP_RD_DATA,
   output orm_pkg::orm_dr_mode_e DUMP_MODE,
   input wire logic [7:0] MAINT_RX_DATA,
   output logic [7:0] MAINT_TX_DATA,
   output logic CLK15_OUT_EN,
   output logic BUFFERED_CRYSTAL_CLOCK_OUT_OUT_EN,
   output logic MODE_MCU,
   output logic MODE_PARALLEL,
   output logic MODE_MASTER,
   output logic GCI_CI_EN,
   output logic GCI_MONITOR_EN
);
   import orm_pkg::*;

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   generate
      if (ADDR_W != 5) begin : g_bad_addr
         $error("orm_overlay_ctrl: ADDR_W must be 5");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------
   logic strap_done_reg;
   logic mcu_reg;
   logic par_reg;
   logic master_reg;

   // Straps are sampled on the first enabled edge after reset release
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         strap_done_reg <= 1'b0;
         mcu_reg <= 1'b0;
         par_reg <= 1'b0;
         master_reg <= 1'b0;
      end else if (CE && !strap_done_reg) begin
         strap_done_reg <= 1'b1;
         mcu_reg <= CTRL_SELECT_STRAP;
         par_reg <= CTRL_SELECT_STRAP & PORT_SELECT_STRAP;
         master_reg <= MASTER_STRAP;
      end
   end

   // Mode outputs follow the captured straps
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         MODE_MCU <= 1'b0;
         MODE_PARALLEL <= 1'b0;
         MODE_MASTER <= 1'b0;
      end else if (CE) begin
         MODE_MCU <= mcu_reg;
         MODE_PARALLEL <= par_reg;
         MODE_MASTER <= master_reg;
      end
   end

   // GCI flags wait for the strap capture, so reset never shows GCI mode
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         GCI_CI_EN <= 1'b0;
         GCI_MONITOR_EN <= 1'b0;
      end else if (CE) begin
         GCI_CI_EN <= strap_done_reg & ~mcu_reg;
         GCI_MONITOR_EN <= strap_done_reg & ~mcu_reg;
      end
   end

   // ----------------------------------------------------------------
   // Parallel port access detection
   // ----------------------------------------------------------------
   logic cs_prev_b_reg;
   logic take;
   logic take_wr;
   logic take_rd;

   // One access per chip-select assertion, so a long select is not repeated
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         cs_prev_b_reg <= 1'b1;
      end else if (CE) begin
         cs_prev_b_reg <= PCP_REQ.cs_b;
      end
   end

   // Accesses only count when the parallel port is the selected control path
   assign take = CE & par_reg & cs_prev_b_reg & ~PCP_REQ.cs_b;
   assign take_wr = take & ~PCP_REQ.rd;
   assign take_rd = take & PCP_REQ.rd;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   logic [7:0] bank_q;
   logic [7:0] cfg2_q;
   logic [7:0] cfg3_q;
   logic [7:0] byte_register_13_q;
   logic [7:0] leg_q;
   logic [7:0] maint_q;
   logic [7:0] dump_q;
   logic ovl_sel;
   logic dump_sel;
   logic hit_bank;
   logic hit_cfg2;
   logic hit_cfg3;
   logic hit_byte_register_13;
   logic hit_dump;
   logic hit_leg;
   logic hit_maint;

   assign ovl_sel = bank_q[ORM_BANK_OVL_BIT];
   assign dump_sel = bank_q[ORM_BANK_DUMP_BIT];
   // Bank select answers whichever set is chosen
   assign hit_bank = (PCP_REQ.addr == ORM_ADDR_BANK);
   assign hit_cfg2 = ovl_sel & (PCP_REQ.addr == ORM_ADDR_CFG2);
   assign hit_cfg3 = ovl_sel & (PCP_REQ.addr == ORM_ADDR_CFG3);
   assign hit_dump = dump_sel & (PCP_REQ.addr == ORM_ADDR_BYTE_REGISTER_13);
   assign hit_byte_register_13 = ~dump_sel & (PCP_REQ.addr == ORM_ADDR_BYTE_REGISTER_13);
   assign hit_leg = ~ovl_sel & (PCP_REQ.addr == ORM_ADDR_LEGCLK);
   assign hit_maint = ~ovl_sel & (PCP_REQ.addr == ORM_ADDR_MAINT);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   orm_byte_reg #(.RST_VAL(ORM_RST_ZERO), .WR_MASK(8'hff)) u_bank (
      .clk(REF_CLK), .rst_b(RST_B), .ce(CE), .clr(SOFT_RST),
      .we(take_wr & hit_bank), .d(PCP_REQ.wdata), .q(bank_q)
   );

   orm_byte_reg #(.RST_VAL(ORM_RST_ZERO), .WR_MASK(ORM_CFG2_RSVD_MASK)) u_cfg2 (
      .clk(REF_CLK), .rst_b(RST_B), .ce(CE), .clr(SOFT_RST),
      .we(take_wr & hit_cfg2), .d(PCP_REQ.wdata), .q(cfg2_q)
   );

   // Zero reset keeps both clock disables off
   orm_byte_reg #(.RST_VAL(ORM_RST_ZERO), .WR_MASK(ORM_CFG3_RSVD_MASK)) u_cfg3 (
      .clk(REF_CLK), .rst_b(RST_B), .ce(CE), .clr(SOFT_RST),
      .we(take_wr & hit_cfg3), .d(PCP_REQ.wdata), .q(cfg3_q)
   );

   orm_byte_reg #(.RST_VAL(ORM_RST_ZERO), .WR_MASK(8'hff)) u_byte_register_13 (
      .clk(REF_CLK), .rst_b(RST_B), .ce(CE), .clr(SOFT_RST),
      .we(take_wr & hit_byte_register_13), .d(PCP_REQ.wdata), .q(byte_register_13_q)
   );

   // Legacy clock bits are dropped on write, so they cannot gate the clocks
   orm_byte_reg #(.RST_VAL(ORM_RST_ZERO), .WR_MASK(ORM_LEG_RSVD_MASK)) u_leg (
      .clk(REF_CLK), .rst_b(RST_B), .ce(CE), .clr(SOFT_RST),
      .we(take_wr & hit_leg), .d(PCP_REQ.wdata), .q(leg_q)
   );

   orm_byte_reg #(.RST_VAL(ORM_RST_ZERO), .WR_MASK(8'hff)) u_maint (
      .clk(REF_CLK), .rst_b(RST_B), .ce(CE), .clr(SOFT_RST),
      .we(take_wr & hit_maint), .d(PCP_REQ.wdata), .q(maint_q)
   );

   // Dump port write side; both resets clear it
   orm_byte_reg #(.RST_VAL(ORM_RST_ZERO), .WR_MASK(8'hff)) u_dump (
      .clk(REF_CLK), .rst_b(RST_B), .ce(CE), .clr(SOFT_RST),
      .we(take_wr & hit_dump), .d(PCP_REQ.wdata), .q(dump_q)
   );

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   logic [7:0] rd_mux;

   // Dump port read returns the mechanism's data, not the written byte
   always_comb begin
      rd_mux = 8'h00;
      if (hit_bank) begin
         rd_mux = bank_q;
      end else if (hit_cfg2) begin
         rd_mux = cfg2_q;
      end else if (hit_cfg3) begin
         rd_mux = cfg3_q;
      end else if (hit_dump) begin
         rd_mux = DUMP_RD_DATA;
      end else if (hit_byte_register_13) begin
         rd_mux = byte_register_13_q;
      end else if (hit_leg) begin
         rd_mux = leg_q;
      end else if (hit_maint) begin
         rd_mux = MAINT_RX_DATA;
      end
   end

   // Data is held and driven until chip select rises
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         PCP_DOUT <= 8'h00;
         PCP_DOE <= 1'b0;
      end else if (CE) begin
         if (take_rd) begin
            PCP_DOUT <= rd_mux;
            PCP_DOE <= 1'b1;
         end else if (PCP_REQ.cs_b) begin
            PCP_DOE <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Dump/restore mechanism side
   // ----------------------------------------------------------------
   // Strobes fire only when bank bit 2 maps the port in
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         DUMP_WR_STB <= 1'b0;
         DUMP_RD_STB <= 1'b0;
      end else if (CE) begin
         DUMP_WR_STB <= take_wr & hit_dump & ~SOFT_RST;
         DUMP_RD_STB <= take_rd & hit_dump & ~SOFT_RST;
      end
   end

   // Write byte is valid with its strobe, so the mechanism needs no extra stage
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         DUMP_WR_DATA <= 8'h00;
      end else if (CE) begin
         DUMP_WR_DATA <= SOFT_RST ? 8'h00 : (take_wr & hit_dump ? PCP_REQ.wdata : dump_q);
      end
   end

   // Mode decode from the two configuration bits {mode1,mode0}
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         DUMP_MODE <= ORM_DR_COEF;
      end else if (CE) begin
         unique case ({cfg2_q[ORM_CFG2_MODE1_BIT], cfg2_q[ORM_CFG2_MODE0_BIT]})
            2'b00: DUMP_MODE <= ORM_DR_COEF;
            2'b10: DUMP_MODE <= ORM_DR_ARC_RD;
            2'b01: DUMP_MODE <= ORM_DR_ARC_WR;
            2'b11: DUMP_MODE <= ORM_DR_SERIAL;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Maintenance channel and clock enables
   // ----------------------------------------------------------------
   // Maintenance byte leaves through a flop, one cycle after the write
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         MAINT_TX_DATA <= 8'h00;
      end else if (CE) begin
         MAINT_TX_DATA <= maint_q;
      end
   end

   // Clocks run out of reset; only configuration register 3 stops them
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         CLK15_OUT_EN <= 1'b1;
         BUFFERED_CRYSTAL_CLOCK_OUT_OUT_EN <= 1'b1;
      end else if (CE) begin
         CLK15_OUT_EN <= ~cfg3_q[ORM_CFG3_CLK15_DIS_BIT];
         BUFFERED_CRYSTAL_CLOCK_OUT_OUT_EN <= ~cfg3_q[ORM_CFG3_BUFX_DIS_BIT];
      end
   end

endmodule

//--- design/orm_pkg.sv
// Package: addresses, field positions, reset values and carriers of the overlay register block
package orm_pkg;

   // ----------------------------------------------------------------
   // Byte addresses on the parallel control port
   // ----------------------------------------------------------------
   localparam logic [4:0] ORM_ADDR_MAINT = 5'h01;
   localparam logic [4:0] ORM_ADDR_CFG2 = 5'h08;
   localparam logic [4:0] ORM_ADDR_CFG3 = 5'h09;
   localparam logic [4:0] ORM_ADDR_BANK = 5'h0a;
   localparam logic [4:0] ORM_ADDR_BYTE_REGISTER_13 = 5'h0d;
   localparam logic [4:0] ORM_ADDR_LEGCLK = 5'h0f;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int ORM_BANK_OVL_BIT = 0;
   localparam int ORM_BANK_DUMP_BIT = 2;
   localparam int ORM_CFG2_MODE0_BIT = 6;
   localparam int ORM_CFG2_MODE1_BIT = 7;
   localparam int ORM_CFG3_BUFX_DIS_BIT = 2;
   localparam int ORM_CFG3_CLK15_DIS_BIT = 1;
   localparam int ORM_LEG_CLK15_BIT = 2;
   localparam int ORM_LEG_BUFX_BIT = 1;

   // ----------------------------------------------------------------
   // Reset values and masks
   // ----------------------------------------------------------------
   localparam logic [7:0] ORM_RST_ZERO = 8'h00;
   localparam logic [7:0] ORM_LEG_RSVD_MASK = 8'hf9;
   localparam logic [7:0] ORM_CFG2_RSVD_MASK = 8'hfb;
   localparam logic [7:0] ORM_CFG3_RSVD_MASK = 8'h7f;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ORM_DR_COEF = 4'b0001,
      ORM_DR_ARC_RD = 4'b0010,
      ORM_DR_ARC_WR = 4'b0100,
      ORM_DR_SERIAL = 4'b1000
   } orm_dr_mode_e;

   typedef struct packed {
      logic cs_b;
      logic rd;
      logic [4:0] addr;
      logic [7:0] wdata;
   } orm_pcp_req_s;

endpackage

//--- verif/orm_host_model.sv
// Host controller model driving the parallel control port
`timescale 1ns/1ps
module orm_host_model (
   input wire logic clk,
   output orm_pkg::orm_pcp_req_s req
);
   import orm_pkg::*;
   // Idle bus, deselected
   initial req = '{cs_b: 1'b1, rd: 1'b0, addr: 5'h00, wdata: 8'h00};
   // One access: select, hold through the answer edge, release, one idle edge
   task automatic access(input logic is_rd, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 req = '{cs_b: 1'b0, rd: is_rd, addr: a, wdata: d};
      repeat (2) @(posedge clk);
      #1 req.cs_b = 1'b1;
      // Released lines show no stale value
      req.addr = ~a;
      req.wdata = ~d;
      @(posedge clk);
      // Hand back off the edge, so callers drive like every other input
      #1;
   endtask
endmodule

//--- verif/orm_overlay_ctrl_asserts.sv
// Port checker of the overlay register block, bound to its top module
`timescale 1ns/1ps
module orm_overlay_ctrl_asserts (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic SOFT_RST,
   input wire orm_pkg::orm_pcp_req_s PCP_REQ,
   input wire logic PCP_DOE,
   input wire logic DUMP_WR_STB,
   input wire logic [7:0] DUMP_WR_DATA,
   input wire logic DUMP_RD_STB,
   input wire orm_pkg::orm_dr_mode_e DUMP_MODE,
   input wire logic CLK15_OUT_EN,
   input wire logic BUFFERED_CRYSTAL_CLOCK_OUT_OUT_EN,
   input wire logic MODE_MCU,
   input wire logic MODE_PARALLEL,
   input wire logic GCI_CI_EN,
   input wire logic GCI_MONITOR_EN
);
   import orm_pkg::*;
   // ----------------------------------------------------------------
   // Port relations
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_B);
   a_wr_stb_pulse: assert property (DUMP_WR_STB |=> !DUMP_WR_STB)
      else $error("dump write strobe longer than one cycle");
   a_wr_stb_cause: assert property (DUMP_WR_STB |-> !$past(PCP_REQ.rd) && $past(PCP_REQ.addr) == ORM_ADDR_BYTE_REGISTER_13)
      else $error("dump write strobe without a write to byte 13");
   a_rd_stb_cause: assert property (DUMP_RD_STB |-> $past(PCP_REQ.rd) && $past(PCP_REQ.addr) == ORM_ADDR_BYTE_REGISTER_13)
      else $error("dump read strobe without a read of byte 13");
   a_stb_apart: assert property (!(DUMP_WR_STB && DUMP_RD_STB))
      else $error("dump read and write strobes together");
   a_mode_onehot: assert property ($onehot(DUMP_MODE))
      else $error("dump mode not one-hot");
   a_gci_flags: assert property (GCI_CI_EN |-> GCI_MONITOR_EN && !MODE_MCU)
      else $error("gci channel flags out of step");
   a_serial_refused: assert property ((!MODE_PARALLEL ##1 !MODE_PARALLEL) |-> !DUMP_WR_STB && !PCP_DOE)
      else $error("parallel access served outside parallel mode");
   a_soft_clear: assert property (CE && SOFT_RST |=> ##1 DUMP_WR_DATA == 8'h00 && CLK15_OUT_EN && BUFFERED_CRYSTAL_CLOCK_OUT_OUT_EN)
      else $error("software reset left state behind");
   a_doe_select: assert property (PCP_DOE |-> !$past(PCP_REQ.cs_b) || !$past(PCP_REQ.cs_b, 2))
      else $error("read data driven without chip select");
   // Main scenarios reached
   c_dump_write: cover property (DUMP_WR_STB);
   c_dump_read: cover property (DUMP_RD_STB);
   c_soft_reset: cover property (SOFT_RST ##2 CLK15_OUT_EN);
endmodule
bind orm_overlay_ctrl orm_overlay_ctrl_asserts i_asserts (.REF_CLK(REF_CLK), .RST_B(RST_B), .CE(CE),
   .SOFT_RST(SOFT_RST), .PCP_REQ(PCP_REQ), .PCP_DOE(PCP_DOE), .DUMP_WR_STB(DUMP_WR_STB),
   .DUMP_WR_DATA(DUMP_WR_DATA), .DUMP_RD_STB(DUMP_RD_STB), .DUMP_MODE(DUMP_MODE), .CLK15_OUT_EN(CLK15_OUT_EN),
   .BUFFERED_CRYSTAL_CLOCK_OUT_OUT_EN(BUFFERED_CRYSTAL_CLOCK_OUT_OUT_EN), .MODE_MCU(MODE_MCU), .MODE_PARALLEL(MODE_PARALLEL),
   .GCI_CI_EN(GCI_CI_EN), .GCI_MONITOR_EN(GCI_MONITOR_EN));

//--- verif/testbench.sv
// Self-checking bench of the overlay register block
`timescale 1ns/1ps
module testbench;
   import orm_pkg::*;
   localparam orm_dr_mode_e MODES [4] = '{ORM_DR_COEF, ORM_DR_ARC_WR, ORM_DR_ARC_RD, ORM_DR_SERIAL};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   int n_rd_stb = 0;
   logic soft_rst = 1'b0;
   logic ctl = 1'b1;
   logic par = 1'b0;
   logic mst = 1'b0;
   logic doe_q = 1'b0;
   logic [7:0] rd_data = 8'h00;
   logic [7:0] rx_data = 8'h00;
   logic [7:0] r = 8'h53;
   logic [7:0] pcp_dout, wr_data, maint_tx;
   logic pcp_doe, wr_stb, rd_stb, clk15_en, bufx_en, mode_mcu, mode_par, mode_mst, ci_en, mon_en;
   orm_dr_mode_e dump_mode;
   orm_pcp_req_s req;
   logic [7:0] expq [$];
   int fails = 0;
   int n_compared = 0;
   always #4 clk = ~clk;
   orm_host_model i_host (.clk(clk), .req(req));
   orm_overlay_ctrl i_orm_overlay_ctrl (.REF_CLK(clk), .RST_B(rst_b), .CE(ce), .SOFT_RST(soft_rst),
      .CTRL_SELECT_STRAP(ctl), .PORT_SELECT_STRAP(par), .MASTER_STRAP(mst), .PCP_REQ(req), .PCP_DOUT(pcp_dout),
      .PCP_DOE(pcp_doe), .DUMP_WR_STB(wr_stb), .DUMP_WR_DATA(wr_data), .DUMP_RD_STB(rd_stb),
      .DUMP_RD_DATA(rd_data), .DUMP_MODE(dump_mode), .MAINT_RX_DATA(rx_data), .MAINT_TX_DATA(maint_tx),
      .CLK15_OUT_EN(clk15_en), .BUFFERED_CRYSTAL_CLOCK_OUT_OUT_EN(bufx_en), .MODE_MCU(mode_mcu), .MODE_PARALLEL(mode_par),
      .MODE_MASTER(mode_mst), .GCI_CI_EN(ci_en), .GCI_MONITOR_EN(mon_en));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("counts: compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      i_host.access(1'b0, a, d);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      expq.push_back(e);
      i_host.access(1'b1, a, 8'h00);
   endtask
   // Reset with given straps, then check every strap-driven level
   task automatic do_reset(input logic c, input logic p);
      rst_b = 1'b0;
      ctl = c;
      par = p;
      mst = p;
      repeat (8) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge clk);
      #1 chk(8'(mode_mcu), 8'(c));
      chk(8'(mode_par), 8'(c & p));
      chk(8'(mode_mst), 8'(p));
      chk(8'({ci_en, mon_en}), c ? 8'h00 : 8'h03);
      chk(8'({clk15_en, bufx_en}), 8'h03);
      chk(8'(dump_mode), 8'(ORM_DR_COEF));
      chk(wr_data, 8'h00);
   endtask
   // Result monitor: oldest note against each write strobe or new read answer; read strobes are only counted
   always @(posedge clk) begin
      #1;
      if (wr_stb === 1'b1 || (pcp_doe === 1'b1 && doe_q !== 1'b1)) begin
         if (expq.size() == 0) chk(8'hee, 8'h00);
         else chk(wr_stb === 1'b1 ? wr_data : pcp_dout, expq.pop_front());
      end
      if (rd_stb === 1'b1) n_rd_stb++;
      doe_q = pcp_doe;
   end
   // Watchdog, far beyond the expected run
   initial begin
      #400000;
      fails++;
      complete_run();
   end
   initial begin
      do_reset(1'b1, 1'b0);
      wr(ORM_ADDR_BANK, 8'h04);
      wr(ORM_ADDR_BYTE_REGISTER_13, 8'h11);
      i_host.access(1'b1, ORM_ADDR_BYTE_REGISTER_13, 8'h00);
      do_reset(1'b0, 1'b1);
      wr(ORM_ADDR_BYTE_REGISTER_13, 8'h22);
      do_reset(1'b1, 1'b1);
      $display("test straps and refusal done");
      wr(ORM_ADDR_BANK, 8'h04);
      rd(ORM_ADDR_BANK, 8'h04);
      for (int i = 0; i < 4; i++) begin
         r = lfsr(r);
         expq.push_back(r);
         wr(ORM_ADDR_BYTE_REGISTER_13, r);
         r = lfsr(r);
         rd_data = r;
         rd(ORM_ADDR_BYTE_REGISTER_13, r);
      end
      wr(ORM_ADDR_BANK, 8'h00);
      wr(ORM_ADDR_BYTE_REGISTER_13, 8'ha5);
      rd_data = 8'h5a;
      rd(ORM_ADDR_BYTE_REGISTER_13, 8'ha5);
      $display("test dump port done");
      wr(ORM_ADDR_BANK, 8'h01);
      rd(ORM_ADDR_BANK, 8'h01);
      foreach (MODES[i]) begin
         wr(ORM_ADDR_CFG2, {i[1:0], 6'h00});
         chk(8'(dump_mode), 8'(MODES[i]));
      end
      wr(ORM_ADDR_BANK, 8'h05);
      r = lfsr(r);
      expq.push_back(r);
      wr(ORM_ADDR_BYTE_REGISTER_13, r);
      chk(8'(dump_mode), 8'(ORM_DR_SERIAL));
      wr(ORM_ADDR_CFG3, 8'h02);
      chk(8'({clk15_en, bufx_en}), 8'h01);
      wr(ORM_ADDR_CFG3, 8'h04);
      chk(8'({clk15_en, bufx_en}), 8'h02);
      $display("test modes and clocks done");
      soft_rst = 1'b1;
      @(posedge clk);
      #1 soft_rst = 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(wr_data, 8'h00);
      chk(8'({clk15_en, bufx_en}), 8'h03);
      chk(8'(dump_mode), 8'(ORM_DR_COEF));
      wr(ORM_ADDR_LEGCLK, 8'h06);
      rd(ORM_ADDR_LEGCLK, 8'h00);
      chk(8'({clk15_en, bufx_en}), 8'h03);
      rx_data = lfsr(r);
      rd(ORM_ADDR_MAINT, rx_data);
      wr(ORM_ADDR_MAINT, r);
      chk(maint_tx, r);
      // Frozen clock enable: a whole access must leave no trace
      ce = 1'b0;
      wr(ORM_ADDR_MAINT, ~r);
      ce = 1'b1;
      @(posedge clk);
      #1 chk(maint_tx, r);
      // Hardware reset must clear a dump port that holds data
      wr(ORM_ADDR_BANK, 8'h04);
      r = lfsr(r);
      expq.push_back(r);
      wr(ORM_ADDR_BYTE_REGISTER_13, r);
      do_reset(1'b1, 1'b1);
      rd(5'h1f, 8'h00);
      repeat (2) @(posedge clk);
      chk(8'(expq.size()), 8'h00);
      chk(8'(n_rd_stb), 8'h04);
      $display("test soft reset and maintenance done");
      complete_run();
   end
endmodule
